// ### core/one_wire_pkg.sv
/*
 * Constants and types for the single-line port burst access block.
 * Assumes a 100 MHz core clock and an 8N1, LSB-first byte format on the line.
 */
package one_wire_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TURN_US         = 20;
  localparam int TURN_CYCLES     = (TURN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BAUD_MIN_BPS    = 4800;
  localparam int BAUD_MAX_BPS    = 115200;
  localparam int BIT_MAX_CYCLES  = CLK_HZ / BAUD_MIN_BPS;
  // rounded down so that the top rate itself is accepted
  localparam int BIT_MIN_CYCLES  = CLK_HZ / BAUD_MAX_BPS;
  localparam int GAP_SHIFT       = 4;
  localparam int CNT_W           = 20;
  localparam int PER_W           = 16;

  // ----------------------------------------
  // frame fields
  // ----------------------------------------
  localparam logic [7:0] SYNC_BYTE     = 8'h55;
  localparam logic [3:0] CMD_WR_NIB    = 4'h1;
  localparam logic [3:0] CMD_RINIT_NIB = 4'h2;
  localparam logic [7:0] CMD_RRESP     = 8'h73;
  localparam logic [7:0] CMD_PM_BWR    = 8'hC1;
  localparam logic [7:0] CMD_DR_BWR    = 8'hB1;
  localparam logic [7:0] CMD_PM_BRD    = 8'hC2;
  localparam logic [7:0] CMD_DR_BRD    = 8'hB2;
  localparam logic [7:0] CMD_BRESP     = 8'hD3;
  localparam int         BURST_LEN     = 8;
  localparam int         BURST_SHIFT   = 3;

  // ----------------------------------------
  // page codes and register page values
  // ----------------------------------------
  localparam logic [2:0] PG_REG0  = 3'h0;
  localparam logic [2:0] PG_DATA  = 3'h1;
  localparam logic [2:0] PG_REG2  = 3'h2;
  localparam logic [2:0] PG_DEV   = 3'h3;
  localparam logic [2:0] PG_PROG  = 3'h4;
  localparam logic [2:0] PG_REG7  = 3'h7;
  localparam logic [7:0] REGSEL_0 = 8'h00;
  localparam logic [7:0] REGSEL_2 = 8'h02;
  localparam logic [7:0] REGSEL_7 = 8'h07;

  // ----------------------------------------
  // error flag positions
  // ----------------------------------------
  localparam int ERR_LO_BAUD = 0;
  localparam int ERR_LO_SYNC = 1;
  localparam int ERR_HI_STOP = 0;
  localparam int ERR_HI_CMD  = 1;

  typedef enum logic [6:0] {
    OP_WR    = 7'b0000001,
    OP_RINIT = 7'b0000010,
    OP_RRESP = 7'b0000100,
    OP_BWR   = 7'b0001000,
    OP_BRD   = 7'b0010000,
    OP_BRESP = 7'b0100000,
    OP_BAD   = 7'b1000000
  } op_t;

  typedef enum logic [9:0] {
    ST_IDLE  = 10'b0000000001,
    ST_SLOW  = 10'b0000000010,
    ST_SBYTE = 10'b0000000100,
    ST_CMD   = 10'b0000001000,
    ST_ADDR  = 10'b0000010000,
    ST_DATA  = 10'b0000100000,
    ST_FETCH = 10'b0001000000,
    ST_TURN  = 10'b0010000000,
    ST_TX    = 10'b0100000000,
    ST_ERR   = 10'b1000000000
  } main_state_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_t;

endpackage : one_wire_pkg

// ### core/line_byte_rx.sv
/*
 * Byte receiver for the single line: 8 data bits LSB first, one stop bit.
 * Assumes the line input is synchronous to clk_in and period_in is stable while armed.
 */
`timescale 1ns/1ps
`default_nettype none

module line_byte_rx (
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  input  wire logic                         line_in,
  input  wire logic [one_wire_pkg::PER_W-1:0] period_in,
  input  wire logic                         arm_in,
  input  wire logic                         resume_in,
  output logic                              byte_valid_out,
  output logic [7:0]                        byte_out,
  output logic                              stop_err_out
);

  one_wire_pkg::rx_state_t          st_q;
  logic [one_wire_pkg::PER_W-1:0]   cnt_q;
  logic [2:0]                       bit_q;
  logic [7:0]                       sh_q;
  logic                             prev_q;

  // ----------------------------------------
  // bit sampling at mid-bit
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q           <= one_wire_pkg::RX_IDLE;
      cnt_q          <= '0;
      bit_q          <= 3'h0;
      sh_q           <= 8'h00;
      prev_q         <= 1'b1;
      byte_valid_out <= 1'b0;
      byte_out       <= 8'h00;
      stop_err_out   <= 1'b0;
    end else begin
      prev_q         <= line_in;
      byte_valid_out <= 1'b0;
      if (resume_in) begin
        // sync byte: start bit already measured, continue at data bit 0
        st_q  <= one_wire_pkg::RX_DATA;
        cnt_q <= period_in >> 1;
        bit_q <= 3'h0;
      end else begin
        case (st_q)
          one_wire_pkg::RX_IDLE: begin
            if (arm_in && prev_q && !line_in) begin
              st_q  <= one_wire_pkg::RX_START;
              cnt_q <= period_in >> 1;
            end
          end
          one_wire_pkg::RX_START: begin
            if (cnt_q == '0) begin
              // a glitch shorter than half a bit is dropped
              st_q  <= line_in ? one_wire_pkg::RX_IDLE : one_wire_pkg::RX_DATA;
              cnt_q <= period_in - 1'b1;
              bit_q <= 3'h0;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          one_wire_pkg::RX_DATA: begin
            if (cnt_q == '0) begin
              sh_q  <= {line_in, sh_q[7:1]};
              cnt_q <= period_in - 1'b1;
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7) begin
                st_q <= one_wire_pkg::RX_STOP;
              end
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          one_wire_pkg::RX_STOP: begin
            if (cnt_q == '0) begin
              byte_valid_out <= 1'b1;
              byte_out       <= sh_q;
              stop_err_out   <= !line_in;
              st_q           <= one_wire_pkg::RX_IDLE;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          default: st_q <= one_wire_pkg::RX_IDLE;
        endcase
      end
    end
  end

endmodule : line_byte_rx

`default_nettype wire

// ### core/one_wire_burst_access.sv
/*
 * Command handler of the single-line port: frames, single and burst memory access,
 * read turnaround and transmit, link error flags.
 * Assumes line_in synchronous to clk_in, memories answer reads in the same cycle as
 * mem_req_out, and page registers are written by the normal single write path.
 */
// Summary of operation
// - C2 plus address prepares eight program bytes
// - B2 plus address prepares eight dev bytes
// - burst address byte is target address bits 10..3
// - D3 frame fetches prepared burst data
// - eight held bytes sent in one frame
// - burst write stores eight bytes, B1 dev
// - command selects operation, target, data count
// - reads use init frame then response frame
// - fetched data held until response frame
// - turnaround 20 us timed, then transmit
// - response carries one or eight bytes
// - baud, sync, stop, command errors flagged
// - three-bit page field selects target memory
// - C1 burst writes eight program bytes
`timescale 1ns/1ps
`default_nettype none

module one_wire_burst_access #(
  parameter logic [15:0] BIT_MAX_CYCLES = 16'(one_wire_pkg::BIT_MAX_CYCLES)
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             line_oe_out,
  input  wire logic [5:0]  program_mem_page_reg_in,
  input  wire logic [5:0]  dev_ram_page_reg_in,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [2:0]       mem_page_out,
  output logic [13:0]      mem_addr_out,
  output logic [7:0]       mem_wdata_out,
  input  wire logic [7:0]  mem_rdata_in,
  output logic [7:0]       register_page_select_out,
  output logic [7:0]       link_error_flags_low_out,
  output logic [7:0]       link_error_flags_high_out,
  input  wire logic [7:0]  err_clear_low_in,
  input  wire logic [7:0]  err_clear_high_in
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic page_ok(input logic [2:0] pg);
    page_ok = (pg != 3'h5) && (pg != 3'h6);
  endfunction : page_ok

  function automatic one_wire_pkg::op_t decode_op(input logic [7:0] c);
    decode_op = one_wire_pkg::OP_BAD;
    if (c == one_wire_pkg::CMD_RRESP) begin
      decode_op = one_wire_pkg::OP_RRESP;
    end else if (c == one_wire_pkg::CMD_BRESP) begin
      decode_op = one_wire_pkg::OP_BRESP;
    end else if (c == one_wire_pkg::CMD_PM_BWR || c == one_wire_pkg::CMD_DR_BWR) begin
      decode_op = one_wire_pkg::OP_BWR;
    end else if (c == one_wire_pkg::CMD_PM_BRD || c == one_wire_pkg::CMD_DR_BRD) begin
      decode_op = one_wire_pkg::OP_BRD;
    end else if (!c[7] && page_ok(c[6:4]) && c[3:0] == one_wire_pkg::CMD_WR_NIB) begin
      decode_op = one_wire_pkg::OP_WR;
    end else if (!c[7] && page_ok(c[6:4]) && c[3:0] == one_wire_pkg::CMD_RINIT_NIB) begin
      decode_op = one_wire_pkg::OP_RINIT;
    end
  endfunction : decode_op

  // ----------------------------------------
  // state
  // ----------------------------------------
  one_wire_pkg::main_state_t        st_q;
  one_wire_pkg::op_t                op_q;
  one_wire_pkg::op_t                op_d;
  logic [one_wire_pkg::CNT_W-1:0]   cnt_q;
  logic [one_wire_pkg::PER_W-1:0]   period_q;
  logic [2:0]                       page_q;
  logic [13:0]                      base_q;
  logic [3:0]                       idx_q;
  logic [3:0]                       n_q;
  logic [3:0]                       tx_bit_q;
  logic [9:0]                       tx_sh_q;
  logic                             prev_q;
  logic [7:0]                       rd_buf_q [0:one_wire_pkg::BURST_LEN-1];
  logic                             cap_q;
  logic [2:0]                       cap_idx_q;
  logic [one_wire_pkg::CNT_W-1:0]   gap_need;
  logic [one_wire_pkg::PER_W-1:0]   rx_period;
  logic                             rx_arm;
  logic                             resume;
  logic                             rx_valid;
  logic [7:0]                       rx_byte;
  logic                             rx_stop_err;
  logic                             ev_baud;
  logic                             ev_sync;
  logic                             ev_stop;
  logic                             ev_cmd;
  logic                             rx_ok;
  logic [13:0]                      single_addr;

  always_comb begin
    op_d      = decode_op(rx_byte);
    gap_need  = {period_q, 4'h0};
    rx_arm    = (st_q == one_wire_pkg::ST_CMD) || (st_q == one_wire_pkg::ST_ADDR) ||
                (st_q == one_wire_pkg::ST_DATA);
    rx_ok     = rx_valid && !rx_stop_err;
    ev_baud   = (st_q == one_wire_pkg::ST_SLOW) &&
                ((line_in && cnt_q < one_wire_pkg::CNT_W'(one_wire_pkg::BIT_MIN_CYCLES)) ||
                 (cnt_q >= one_wire_pkg::CNT_W'(BIT_MAX_CYCLES)));
    resume    = (st_q == one_wire_pkg::ST_SLOW) && line_in && !ev_baud;
    rx_period = resume ? cnt_q[one_wire_pkg::PER_W-1:0] : period_q;
    ev_sync   = (st_q == one_wire_pkg::ST_SBYTE) && rx_ok && (rx_byte != one_wire_pkg::SYNC_BYTE);
    ev_stop   = rx_valid && rx_stop_err && (rx_arm || st_q == one_wire_pkg::ST_SBYTE);
    ev_cmd    = (st_q == one_wire_pkg::ST_CMD) && rx_ok && (op_d == one_wire_pkg::OP_BAD);
    case (page_q)
      one_wire_pkg::PG_PROG: single_addr = {program_mem_page_reg_in, rx_byte};
      one_wire_pkg::PG_DEV:  single_addr = {dev_ram_page_reg_in, rx_byte};
      default:               single_addr = {6'h00, rx_byte};
    endcase
  end

  line_byte_rx u_rx (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .line_in        (line_in),
    .period_in      (rx_period),
    .arm_in         (rx_arm),
    .resume_in      (resume),
    .byte_valid_out (rx_valid),
    .byte_out       (rx_byte),
    .stop_err_out   (rx_stop_err)
  );

  // ----------------------------------------
  // frame sequencing
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q        <= one_wire_pkg::ST_IDLE;
      op_q        <= one_wire_pkg::OP_BAD;
      cnt_q       <= '0;
      period_q    <= '0;
      page_q      <= 3'h0;
      base_q      <= 14'h0000;
      idx_q       <= 4'h0;
      n_q         <= 4'h1;
      tx_bit_q    <= 4'h0;
      tx_sh_q     <= 10'h3FF;
      prev_q      <= 1'b1;
      line_out    <= 1'b1;
      line_oe_out <= 1'b0;
      mem_req_out <= 1'b0;
      mem_we_out  <= 1'b0;
      mem_page_out  <= 3'h0;
      mem_addr_out  <= 14'h0000;
      mem_wdata_out <= 8'h00;
      register_page_select_out <= one_wire_pkg::REGSEL_0;
    end else begin
      prev_q      <= line_in;
      mem_req_out <= 1'b0;
      case (st_q)
        one_wire_pkg::ST_IDLE: begin
          line_oe_out <= 1'b0;
          if (prev_q && !line_in) begin
            st_q  <= one_wire_pkg::ST_SLOW;
            cnt_q <= 20'h00001;
          end
        end
        one_wire_pkg::ST_SLOW: begin
          if (ev_baud) begin
            st_q  <= one_wire_pkg::ST_ERR;
            cnt_q <= '0;
          end else if (line_in) begin
            period_q <= cnt_q[one_wire_pkg::PER_W-1:0];
            st_q     <= one_wire_pkg::ST_SBYTE;
            cnt_q    <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        one_wire_pkg::ST_SBYTE, one_wire_pkg::ST_CMD, one_wire_pkg::ST_ADDR, one_wire_pkg::ST_DATA: begin
          cnt_q <= rx_valid ? '0 : cnt_q + 1'b1;
          if (ev_stop || ev_sync || ev_cmd) begin
            st_q  <= one_wire_pkg::ST_ERR;
            cnt_q <= '0;
          end else if (!rx_valid && cnt_q >= gap_need) begin
            // master went quiet mid-frame: drop the frame
            st_q <= one_wire_pkg::ST_IDLE;
          end else if (rx_valid && st_q == one_wire_pkg::ST_SBYTE) begin
            st_q <= one_wire_pkg::ST_CMD;
          end else if (rx_valid && st_q == one_wire_pkg::ST_CMD) begin
            op_q   <= op_d;
            page_q <= rx_byte[6:4];
            idx_q  <= 4'h0;
            if (op_d == one_wire_pkg::OP_BWR || op_d == one_wire_pkg::OP_BRD ||
                op_d == one_wire_pkg::OP_BRESP) begin
              n_q <= 4'(one_wire_pkg::BURST_LEN);
            end else begin
              n_q <= 4'h1;
            end
            if (op_d == one_wire_pkg::OP_RRESP || op_d == one_wire_pkg::OP_BRESP) begin
              st_q  <= one_wire_pkg::ST_TURN;
              cnt_q <= '0;
            end else begin
              st_q <= one_wire_pkg::ST_ADDR;
            end
            if (rx_byte == one_wire_pkg::CMD_PM_BWR || rx_byte == one_wire_pkg::CMD_PM_BRD) begin
              page_q <= one_wire_pkg::PG_PROG;
            end else if (rx_byte == one_wire_pkg::CMD_DR_BWR || rx_byte == one_wire_pkg::CMD_DR_BRD) begin
              page_q <= one_wire_pkg::PG_DEV;
            end
          end else if (rx_valid && st_q == one_wire_pkg::ST_ADDR) begin
            if (op_q == one_wire_pkg::OP_BWR || op_q == one_wire_pkg::OP_BRD) begin
              base_q <= (page_q == one_wire_pkg::PG_PROG) ?
                        {program_mem_page_reg_in[5:3], rx_byte, 3'h0} :
                        {dev_ram_page_reg_in[5:3], rx_byte, 3'h0};
            end else begin
              base_q <= single_addr;
            end
            case (page_q)
              one_wire_pkg::PG_REG0: register_page_select_out <= one_wire_pkg::REGSEL_0;
              one_wire_pkg::PG_REG2: register_page_select_out <= one_wire_pkg::REGSEL_2;
              one_wire_pkg::PG_REG7: register_page_select_out <= one_wire_pkg::REGSEL_7;
              default:               register_page_select_out <= register_page_select_out;
            endcase
            st_q <= (op_q == one_wire_pkg::OP_RINIT || op_q == one_wire_pkg::OP_BRD) ?
                    one_wire_pkg::ST_FETCH : one_wire_pkg::ST_DATA;
          end else if (rx_valid && st_q == one_wire_pkg::ST_DATA) begin
            // each byte is stored as soon as it arrives
            mem_req_out   <= 1'b1;
            mem_we_out    <= 1'b1;
            mem_page_out  <= page_q;
            mem_addr_out  <= base_q + {10'h000, idx_q};
            mem_wdata_out <= rx_byte;
            idx_q         <= idx_q + 4'h1;
            if (idx_q == n_q - 4'h1) begin
              st_q <= one_wire_pkg::ST_IDLE;
            end
          end
        end
        one_wire_pkg::ST_FETCH: begin
          if (idx_q == n_q) begin
            st_q <= one_wire_pkg::ST_IDLE;
          end else begin
            mem_req_out  <= 1'b1;
            mem_we_out   <= 1'b0;
            mem_page_out <= page_q;
            mem_addr_out <= base_q + {10'h000, idx_q};
            idx_q        <= idx_q + 4'h1;
          end
        end
        one_wire_pkg::ST_TURN: begin
          line_oe_out <= 1'b0;
          if (cnt_q == one_wire_pkg::CNT_W'(one_wire_pkg::TURN_CYCLES - 1)) begin
            st_q        <= one_wire_pkg::ST_TX;
            cnt_q       <= '0;
            tx_bit_q    <= 4'h0;
            tx_sh_q     <= {1'b1, rd_buf_q[0], 1'b0};
            line_out    <= 1'b0;
            line_oe_out <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        one_wire_pkg::ST_TX: begin
          if (cnt_q[one_wire_pkg::PER_W-1:0] == period_q - 1'b1) begin
            cnt_q <= '0;
            if (tx_bit_q == 4'h9) begin
              idx_q <= idx_q + 4'h1;
              if (idx_q == n_q - 4'h1) begin
                st_q        <= one_wire_pkg::ST_IDLE;
                line_out    <= 1'b1;
                line_oe_out <= 1'b0;
              end else begin
                tx_bit_q <= 4'h0;
                tx_sh_q  <= {1'b1, rd_buf_q[3'(idx_q + 4'h1)], 1'b0};
                line_out <= 1'b0;
              end
            end else begin
              tx_bit_q <= tx_bit_q + 4'h1;
              tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
              line_out <= tx_sh_q[1];
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        one_wire_pkg::ST_ERR: begin
          // wait for a quiet line before hunting for the next sync
          line_oe_out <= 1'b0;
          cnt_q       <= line_in ? cnt_q + 1'b1 : '0;
          if (line_in && cnt_q >= gap_need) begin
            st_q <= one_wire_pkg::ST_IDLE;
          end
        end
        default: st_q <= one_wire_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // read data capture, held until a response frame
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_q     <= 1'b0;
      cap_idx_q <= 3'h0;
      for (int i = 0; i < one_wire_pkg::BURST_LEN; i++) begin
        rd_buf_q[i] <= 8'h00;
      end
    end else begin
      cap_q     <= (st_q == one_wire_pkg::ST_FETCH) && (idx_q != n_q);
      cap_idx_q <= idx_q[2:0];
      if (cap_q) begin
        rd_buf_q[cap_idx_q] <= mem_rdata_in;
      end
    end
  end

  // ----------------------------------------
  // sticky error flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_error_flags_low_out  <= 8'h00;
      link_error_flags_high_out <= 8'h00;
    end else begin
      link_error_flags_low_out  <= (link_error_flags_low_out & ~err_clear_low_in) |
                                   (8'(ev_baud) << one_wire_pkg::ERR_LO_BAUD) |
                                   (8'(ev_sync) << one_wire_pkg::ERR_LO_SYNC);
      link_error_flags_high_out <= (link_error_flags_high_out & ~err_clear_high_in) |
                                   (8'(ev_stop) << one_wire_pkg::ERR_HI_STOP) |
                                   (8'(ev_cmd) << one_wire_pkg::ERR_HI_CMD);
    end
  end

endmodule : one_wire_burst_access

`default_nettype wire

// ### verif/one_wire_burst_access_checker.sv
/* Concurrent checks on the single-line port block, bound to its ports.
   Assumes one clock and a bit period of 868 cycles on the line. */
`timescale 1ns/1ps
`default_nettype none
module one_wire_burst_access_checker (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        line_in,
  input wire logic        line_out,
  input wire logic        line_oe_out,
  input wire logic        mem_req_out,
  input wire logic        mem_we_out,
  input wire logic [2:0]  mem_page_out,
  input wire logic [13:0] mem_addr_out,
  input wire logic [7:0]  link_error_flags_low_out,
  input wire logic [7:0]  err_clear_low_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // quiet and transmit run counters
  // ----------------------------------------
  logic [16:0] hi_q;
  logic [16:0] on_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in || !line_in || line_oe_out) hi_q <= '0;
    else if (hi_q != '1) hi_q <= hi_q + 17'h1;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in || !line_oe_out) on_q <= '0;
    else on_q <= on_q + 17'h1;
  end
  chk_idle_level_high: assert property (!line_oe_out |-> line_out)
    else $error("line not high while released");
  chk_turn_quiet: assert property ($rose(line_oe_out) |-> hi_q inside {[2000:4400]})
    else $error("transmit began without turnaround");
  chk_frame_len: assert property ($fell(line_oe_out) |-> on_q inside {[8679:8681], [69439:69441]})
    else $error("response length not one or eight bytes");
  chk_write_single: assert property (mem_req_out && mem_we_out |=> !mem_req_out)
    else $error("write pulse longer than one cycle");
  chk_burst_eight: assert property ($rose(mem_req_out) && !mem_we_out ##1 mem_req_out |->
    mem_req_out [*7] ##1 !mem_req_out)
    else $error("burst fetch not eight reads");
  chk_addr_step: assert property (mem_req_out && !mem_we_out && $past(mem_req_out) |->
    mem_addr_out == $past(mem_addr_out) + 14'h1)
    else $error("burst fetch address not consecutive");
  chk_burst_align: assert property ($rose(mem_req_out) && !mem_we_out ##1 mem_req_out |->
    $past(mem_addr_out[2:0]) == 3'h0)
    else $error("burst fetch not group aligned");
  chk_page_legal: assert property (mem_req_out |-> mem_page_out != 3'h5 && mem_page_out != 3'h6)
    else $error("access to reserved page");
  chk_sync_sticky: assert property ($fell(link_error_flags_low_out[one_wire_pkg::ERR_LO_SYNC]) |->
    $past(err_clear_low_in[one_wire_pkg::ERR_LO_SYNC]))
    else $error("sync flag dropped without clear");
  cover property ($rose(line_oe_out));
  cover property (mem_req_out && mem_we_out);
  cover property ($rose(link_error_flags_low_out[one_wire_pkg::ERR_LO_SYNC]));
endmodule : one_wire_burst_access_checker
bind one_wire_burst_access one_wire_burst_access_checker chk (.clk_in, .rst_in, .line_in, .line_out,
  .line_oe_out, .mem_req_out, .mem_we_out, .mem_page_out, .mem_addr_out, .link_error_flags_low_out,
  .err_clear_low_in);
`default_nettype wire

// ### verif/line_master_model.sv
/* Behavioural line master: sends 8N1 bytes LSB first, receives device bytes.
   Assumes a pull-up on the line, so a released driver reads high. */
`timescale 1ns/1ps
`default_nettype none
module line_master_model #(
  parameter int PER = 868
) (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      drive_out
);
  initial drive_out = 1'b1;
  // stop bit leaves the driver released (high) until the next frame
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drive_out <= f[i];
      repeat (PER) @(posedge clk_in);
    end
  endtask : send
  // samples mid-bit; no bound here, the bench timeout catches a silent device
  task automatic recv(output logic [7:0] b);
    while (line_in !== 1'b0) @(posedge clk_in);
    repeat (PER / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (PER) @(posedge clk_in);
      b[i] = line_in;
    end
    repeat (PER) @(posedge clk_in);
  endtask : recv
endmodule : line_master_model
`default_nettype wire

// ### verif/test_one_wire_burst_access.sv
/* Bench: dev burst write, program burst read with turnaround, bad sync and clear.
   Assumes the line model and checker files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_one_wire_burst_access;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [5:0]  pg_q   = 6'h00;
  logic [7:0]  clr_q  = 8'h00;
  logic [2:0]  ep     = one_wire_pkg::PG_DEV;
  logic        ew     = 1'b1;
  logic [7:0]  b, flo, fhi, wd;
  logic [13:0] ad;
  logic [2:0]  pgo;
  logic        lo, oe, req, we, drv;
  int          bad_count = 0, cmp_count = 0, an = 0, cyc = 0;
  wire logic   line_w = oe ? lo : drv;
  // asynchronous read: data stands in the request cycle, where the device takes it
  wire logic [7:0] rd_q = ad[7:0] ^ 8'h5A;
  // ----------------------------------------
  // device, line master, memory model
  // ----------------------------------------
  one_wire_burst_access #(.BIT_MAX_CYCLES(16'h07D0)) uut (.clk_in, .rst_in, .line_in(line_w),
    .line_out(lo), .line_oe_out(oe), .program_mem_page_reg_in(pg_q), .dev_ram_page_reg_in(pg_q),
    .mem_req_out(req), .mem_we_out(we), .mem_page_out(pgo), .mem_addr_out(ad), .mem_wdata_out(wd),
    .mem_rdata_in(rd_q), .register_page_select_out(), .link_error_flags_low_out(flo),
    .link_error_flags_high_out(fhi), .err_clear_low_in(clr_q), .err_clear_high_in(clr_q));
  line_master_model mdl (.clk_in, .line_in(line_w), .drive_out(drv));
  initial forever #5 clk_in = ~clk_in;
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic frame3(input logic [7:0] c);
    mdl.send(one_wire_pkg::SYNC_BYTE);
    mdl.send(c);
    mdl.send(8'hEC);
  endtask : frame3
  // read data is a function of the address so a wrong fetch shows on the line
  always @(posedge clk_in) if (req === 1'b1) begin
    check("mem_addr", 16'(ad), 16'(14'h1760 + 14'(an)));
    check("mem_page", 16'(pgo), 16'(ep));
    check("mem_we", 16'(we), 16'(ew));
    if (ew) check("mem_wdata", 16'(wd), 16'(8'h30 + 8'(an)));
    an++;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 400000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    pg_q   <= 6'h17;
    repeat (4) @(posedge clk_in);
    frame3(one_wire_pkg::CMD_DR_BWR);
    for (int i = 0; i < 8; i++) mdl.send(8'h30 + 8'(i));
    repeat (50) @(posedge clk_in);
    check("wr_count", 16'(an), 16'h0008);
    an = 0;
    ep = one_wire_pkg::PG_PROG;
    ew = 1'b0;
    frame3(one_wire_pkg::CMD_PM_BRD);
    repeat (3000) @(posedge clk_in);
    check("rd_count", 16'(an), 16'h0008);
    check("oe_held", 16'(oe), 16'h0000);
    mdl.send(one_wire_pkg::SYNC_BYTE);
    mdl.send(one_wire_pkg::CMD_BRESP);
    for (int i = 0; i < 8; i++) begin
      mdl.recv(b);
      check("rx_byte", 16'(b), 16'((8'h60 + 8'(i)) ^ 8'h5A));
    end
    repeat (900) @(posedge clk_in);
    check("oe_done", 16'(oe), 16'h0000);
    mdl.send(one_wire_pkg::SYNC_BYTE);
    mdl.send(one_wire_pkg::CMD_RRESP);
    mdl.recv(b);
    check("rx_single", 16'(b), 16'(8'h60 ^ 8'h5A));
    repeat (900) @(posedge clk_in);
    mdl.send(8'h57);
    repeat (16000) @(posedge clk_in);
    check("sync_err", 16'(flo), 16'(8'h01 << one_wire_pkg::ERR_LO_SYNC));
    check("stop_err", 16'(fhi), 16'h0000);
    clr_q <= flo;
    @(posedge clk_in);
    clr_q <= 8'h00;
    repeat (2) @(posedge clk_in);
    check("sync_clr", 16'(flo), 16'h0000);
    tally_and_finish();
  end
endmodule : test_one_wire_burst_access
`default_nettype wire
